// *** src/addr_decoder_consts.svh ***
// address map constants for the system address decoder
`ifndef ADDR_DECODER_CONSTS_SVH
`define ADDR_DECODER_CONSTS_SVH
`define AD_IO_LO_START      16'h0000
`define AD_IO_LO_END        16'h003f
`define AD_RAM_A_START      16'h0040
`define AD_RAM_A_END        16'h043f
`define AD_IO_HI_START      16'h0440
`define AD_IO_HI_END        16'h0461
`define AD_FLASH_B0_START   16'h0462
`define AD_FLASH_B0_END     16'h04ff
`define AD_CAN_START        16'h0500
`define AD_CAN_END          16'h057f
`define AD_RAM_B_START      16'h0580
`define AD_RAM_B_END        16'h097f
`define AD_FLASH_B1_START   16'h0980
`define AD_FLASH_B1_END     16'h1b7f
`define AD_RSV0_START       16'h1b80
`define AD_RSV0_END         16'h1dff
`define AD_MON_A_START      16'h1e00
`define AD_MON_A_END        16'h1e0f
`define AD_RSV1_START       16'h1e10
`define AD_RSV1_END         16'h1e1f
`define AD_FLASH_B2_START   16'h1e20
`define AD_FLASH_B2_END     16'h7fff
`define AD_FLASH_A_START    16'h8000
`define AD_FLASH_A_END      16'hfdff
`define AD_BREAK_STATE      16'hfe00
`define AD_RESET_CAUSE      16'hfe01
`define AD_RSV_FE02         16'hfe02
`define AD_BREAK_FLAG_CTRL  16'hfe03
`define AD_IRQ_STATUS_BASE  16'hfe04
`define AD_FLASH_B_CTRL     16'hfe08
`define AD_BREAK_ADDR_HIGH  16'hfe09
`define AD_BREAK_ADDR_LOW   16'hfe0a
`define AD_BREAK_CTRL_STATE 16'hfe0b
`define AD_LOW_VOLT_STATE   16'hfe0c
`define AD_FLASH_B_TEST     16'hfe0d
`define AD_FLASH_A_TEST     16'hfe0e
`define AD_UNIMPL_FE0F      16'hfe0f
`define AD_MON_COMPAT_START 16'hfe10
`define AD_MON_COMPAT_END   16'hfe1f
`define AD_MON_B_START      16'hfe20
`define AD_MON_B_END        16'hff7f
`define AD_FLASH_A_PROTECT  16'hff80
`define AD_FLASH_B_PROTECT  16'hff81
`define AD_RSV2_START       16'hff82
`define AD_RSV2_END         16'hff87
`define AD_FLASH_A_CTRL     16'hff88
`define AD_RSV3_START       16'hff89
`define AD_RSV3_END         16'hffcb
`define AD_VECTOR_START     16'hffcc
`define AD_VECTOR_END       16'hffff
`define AD_IRQ_STATUS_COUNT 4
`define AD_FLASH_BYTES      62078
`define AD_RAM_BYTES        2048
`define AD_VECTOR_BYTES     52
`endif

// *** src/addr_decoder_pkg.sv ***
// types for the system address decoder
package addr_decoder_pkg;
   typedef enum logic [4:0] {
      REG_IO_LO, REG_RAM_A, REG_IO_HI, REG_FLASH_B, REG_CAN, REG_RAM_B,
      REG_MON_ROM, REG_FLASH_A, REG_BREAK_STATE, REG_RESET_CAUSE,
      REG_BREAK_FLAG_CTRL, REG_IRQ_STATUS, REG_FLASH_B_CTRL,
      REG_BREAK_ADDR_HIGH, REG_BREAK_ADDR_LOW, REG_BREAK_CTRL_STATE,
      REG_LOW_VOLT_STATE, REG_FLASH_B_TEST, REG_FLASH_A_TEST,
      REG_FLASH_A_PROTECT, REG_FLASH_B_PROTECT, REG_VECTOR,
      REG_RESERVED, REG_UNIMPL, REG_FLASH_A_CTRL
   } region_e;
endpackage

// *** src/range_match.sv ***
// inclusive address range comparator
`timescale 1ns/1ps
module range_match #(
   parameter logic [15:0] LO = 16'h0000,
   parameter logic [15:0] HI = 16'h0000
) (
   input  wire logic [15:0] addr_in,
   output wire logic        hit_out
);
   assign hit_out = (addr_in >= LO) && (addr_in <= HI);
endmodule

// *** src/system_address_decoder.sv ***
// registered region and register-select decoder for the 16-bit cpu bus
// Contract
// - take a 16-bit address, 64 KB space, every address one region.
// - flash regions together total 62,078 bytes of program storage.
// - two ram regions together total 2048 bytes.
// - 52 bytes at the top are decoded as user vectors.
// - an access to an unimplemented location requests illegal-address reset.
// - 128-byte window selects the can controller buffer space.
// - 0xfe00 selects break state, 0xfe01 reset cause register.
// - 0xfe03 selects the break flag control register.
// - 0xfe04 to 0xfe07 select irq status registers one to four.
// - 0xfe08 flash b control; 0xfe0d, 0xfe0e flash b and a test.
// - 0xfe09, 0xfe0a break address high/low; 0xfe0b break control/state.
// - 0xfe0c selects the low-voltage state register.
// - 16 bytes from 0xfe10 decoded as reserved monitor compatibility space.
// - 0xff80, 0xff81 flash a/b protect; 0xff88 flash a control.
`timescale 1ns/1ps
`include "addr_decoder_consts.svh"
module system_address_decoder (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   output logic             io_lo_sel_out,
   output logic             ram_a_sel_out,
   output logic             io_hi_sel_out,
   output logic             flash_b_sel_out,
   output logic             can_sel_out,
   output logic             ram_b_sel_out,
   output logic             mon_rom_sel_out,
   output logic             flash_a_sel_out,
   output logic             vector_sel_out,
   output logic             break_state_reg_sel_out,
   output logic             reset_cause_reg_sel_out,
   output logic             break_flag_ctrl_reg_sel_out,
   output logic [3:0]       irq_status_sel_out,
   output logic             flash_b_ctrl_reg_sel_out,
   output logic             break_addr_high_sel_out,
   output logic             break_addr_low_sel_out,
   output logic             break_ctrl_state_reg_sel_out,
   output logic             low_voltage_state_reg_sel_out,
   output logic             flash_b_test_reg_sel_out,
   output logic             flash_a_test_reg_sel_out,
   output logic             flash_a_protect_reg_sel_out,
   output logic             flash_b_protect_reg_sel_out,
   output logic             reserved_hit_out,
   output logic             illegal_addr_rst_out,
   output addr_decoder_pkg::region_e region_out
);
   wire logic access = rd_in | wr_in;
   wire logic h_io_lo, h_ram_a, h_io_hi, h_fb0, h_can, h_ram_b, h_fb1;
   wire logic h_rsv0, h_mon_a, h_rsv1, h_fb2, h_fa, h_mon_compat;
   wire logic h_mon_b, h_rsv2, h_rsv3, h_vec;
   wire logic [3:0] h_irq;

   // contiguous ranges tile the 64 KB space except 0xfe00-0xfe0f, 0xff80, 0xff81 and 0xff88
   range_match #(.LO(`AD_IO_LO_START), .HI(`AD_IO_LO_END)) u_io_lo
      (.addr_in(addr_in), .hit_out(h_io_lo));
   range_match #(.LO(`AD_RAM_A_START), .HI(`AD_RAM_A_END)) u_ram_a
      (.addr_in(addr_in), .hit_out(h_ram_a));
   range_match #(.LO(`AD_IO_HI_START), .HI(`AD_IO_HI_END)) u_io_hi
      (.addr_in(addr_in), .hit_out(h_io_hi));
   range_match #(.LO(`AD_FLASH_B0_START), .HI(`AD_FLASH_B0_END)) u_fb0
      (.addr_in(addr_in), .hit_out(h_fb0));
   range_match #(.LO(`AD_CAN_START), .HI(`AD_CAN_END)) u_can
      (.addr_in(addr_in), .hit_out(h_can));
   range_match #(.LO(`AD_RAM_B_START), .HI(`AD_RAM_B_END)) u_ram_b
      (.addr_in(addr_in), .hit_out(h_ram_b));
   range_match #(.LO(`AD_FLASH_B1_START), .HI(`AD_FLASH_B1_END)) u_fb1
      (.addr_in(addr_in), .hit_out(h_fb1));
   range_match #(.LO(`AD_RSV0_START), .HI(`AD_RSV0_END)) u_rsv0
      (.addr_in(addr_in), .hit_out(h_rsv0));
   range_match #(.LO(`AD_MON_A_START), .HI(`AD_MON_A_END)) u_mon_a
      (.addr_in(addr_in), .hit_out(h_mon_a));
   range_match #(.LO(`AD_RSV1_START), .HI(`AD_RSV1_END)) u_rsv1
      (.addr_in(addr_in), .hit_out(h_rsv1));
   range_match #(.LO(`AD_FLASH_B2_START), .HI(`AD_FLASH_B2_END)) u_fb2
      (.addr_in(addr_in), .hit_out(h_fb2));
   range_match #(.LO(`AD_FLASH_A_START), .HI(`AD_FLASH_A_END)) u_fa
      (.addr_in(addr_in), .hit_out(h_fa));
   range_match #(.LO(`AD_MON_COMPAT_START), .HI(`AD_MON_COMPAT_END)) u_mc
      (.addr_in(addr_in), .hit_out(h_mon_compat));
   range_match #(.LO(`AD_MON_B_START), .HI(`AD_MON_B_END)) u_mon_b
      (.addr_in(addr_in), .hit_out(h_mon_b));
   range_match #(.LO(`AD_RSV2_START), .HI(`AD_RSV2_END)) u_rsv2
      (.addr_in(addr_in), .hit_out(h_rsv2));
   range_match #(.LO(`AD_RSV3_START), .HI(`AD_RSV3_END)) u_rsv3
      (.addr_in(addr_in), .hit_out(h_rsv3));
   range_match #(.LO(`AD_VECTOR_START), .HI(`AD_VECTOR_END)) u_vec
      (.addr_in(addr_in), .hit_out(h_vec));

   genvar gi;
   generate
      for (gi = 0; gi < `AD_IRQ_STATUS_COUNT; gi = gi + 1)
      begin : g_irq
         // ascending order from the base slot
         assign h_irq[gi] = (addr_in == (`AD_IRQ_STATUS_BASE + 16'(gi)));
      end
   endgenerate

   wire logic h_bs   = (addr_in == `AD_BREAK_STATE);
   wire logic h_rc   = (addr_in == `AD_RESET_CAUSE);
   wire logic h_bfc  = (addr_in == `AD_BREAK_FLAG_CTRL);
   wire logic h_fbc  = (addr_in == `AD_FLASH_B_CTRL);
   wire logic h_bah  = (addr_in == `AD_BREAK_ADDR_HIGH);
   wire logic h_bal  = (addr_in == `AD_BREAK_ADDR_LOW);
   wire logic h_bcs  = (addr_in == `AD_BREAK_CTRL_STATE);
   wire logic h_lvs  = (addr_in == `AD_LOW_VOLT_STATE);
   wire logic h_fbt  = (addr_in == `AD_FLASH_B_TEST);
   wire logic h_fat  = (addr_in == `AD_FLASH_A_TEST);
   wire logic h_fap  = (addr_in == `AD_FLASH_A_PROTECT);
   wire logic h_fbp  = (addr_in == `AD_FLASH_B_PROTECT);
   wire logic h_fac  = (addr_in == `AD_FLASH_A_CTRL);
   wire logic h_unim = (addr_in == `AD_UNIMPL_FE0F);
   wire logic h_r02  = (addr_in == `AD_RSV_FE02);

   wire logic h_rsv = h_rsv0 | h_rsv1 | h_rsv2 | h_rsv3 | h_r02
                    | h_mon_compat;
   wire logic h_mon = h_mon_a | h_mon_b;
   wire logic h_fb  = h_fb0 | h_fb1 | h_fb2;

   // ranges are disjoint, so priority only picks a name
   addr_decoder_pkg::region_e region_d;
   always_comb
   begin
      region_d = addr_decoder_pkg::REG_UNIMPL;
      if (h_io_lo) region_d = addr_decoder_pkg::REG_IO_LO;
      else if (h_ram_a) region_d = addr_decoder_pkg::REG_RAM_A;
      else if (h_io_hi) region_d = addr_decoder_pkg::REG_IO_HI;
      else if (h_fb) region_d = addr_decoder_pkg::REG_FLASH_B;
      else if (h_can) region_d = addr_decoder_pkg::REG_CAN;
      else if (h_ram_b) region_d = addr_decoder_pkg::REG_RAM_B;
      else if (h_mon) region_d = addr_decoder_pkg::REG_MON_ROM;
      else if (h_fa) region_d = addr_decoder_pkg::REG_FLASH_A;
      else if (h_bs) region_d = addr_decoder_pkg::REG_BREAK_STATE;
      else if (h_rc) region_d = addr_decoder_pkg::REG_RESET_CAUSE;
      else if (h_bfc) region_d = addr_decoder_pkg::REG_BREAK_FLAG_CTRL;
      else if (|h_irq) region_d = addr_decoder_pkg::REG_IRQ_STATUS;
      else if (h_fbc) region_d = addr_decoder_pkg::REG_FLASH_B_CTRL;
      else if (h_bah) region_d = addr_decoder_pkg::REG_BREAK_ADDR_HIGH;
      else if (h_bal) region_d = addr_decoder_pkg::REG_BREAK_ADDR_LOW;
      else if (h_bcs) region_d = addr_decoder_pkg::REG_BREAK_CTRL_STATE;
      else if (h_lvs) region_d = addr_decoder_pkg::REG_LOW_VOLT_STATE;
      else if (h_fbt) region_d = addr_decoder_pkg::REG_FLASH_B_TEST;
      else if (h_fat) region_d = addr_decoder_pkg::REG_FLASH_A_TEST;
      else if (h_fap) region_d = addr_decoder_pkg::REG_FLASH_A_PROTECT;
      else if (h_fbp) region_d = addr_decoder_pkg::REG_FLASH_B_PROTECT;
      else if (h_fac) region_d = addr_decoder_pkg::REG_FLASH_A_CTRL;
      else if (h_vec) region_d = addr_decoder_pkg::REG_VECTOR;
      else if (h_rsv) region_d = addr_decoder_pkg::REG_RESERVED;
   end

   // selects gated by a bus strobe: no strobe, no select
   // bit order matches the output assignments below, msb first
   wire logic [25:0] sel_d = {26{access}} & {
      h_io_lo,
      h_ram_a,
      h_io_hi,
      h_fb,
      h_can,
      h_ram_b,
      h_mon,
      h_fa,
      h_vec,
      h_bs,
      h_rc,
      h_bfc,
      h_irq,
      h_fbc,
      h_bah,
      h_bal,
      h_bcs,
      h_lvs,
      h_fbt,
      h_fat,
      h_fap,
      h_fbp,
      h_rsv};
   // only 0xfe0f resets the part; reserved holes merely flag a hit
   wire logic illegal_d = access & h_unim;

   logic [25:0] sel_q;
   logic        illegal_q;
   addr_decoder_pkg::region_e region_q;
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         sel_q     <= 26'h0;
         illegal_q <= 1'b0;
         region_q  <= addr_decoder_pkg::REG_UNIMPL;
      end
      else
      begin
         sel_q     <= sel_d;
         illegal_q <= illegal_d;
         region_q  <= region_d;
      end
   end

   assign io_lo_sel_out                 = sel_q[25];
   assign ram_a_sel_out                 = sel_q[24];
   assign io_hi_sel_out                 = sel_q[23];
   assign flash_b_sel_out               = sel_q[22];
   assign can_sel_out                   = sel_q[21];
   assign ram_b_sel_out                 = sel_q[20];
   assign mon_rom_sel_out               = sel_q[19];
   assign flash_a_sel_out               = sel_q[18];
   assign vector_sel_out                = sel_q[17];
   assign break_state_reg_sel_out       = sel_q[16];
   assign reset_cause_reg_sel_out       = sel_q[15];
   assign break_flag_ctrl_reg_sel_out   = sel_q[14];
   // bit 0 of the irq status selects is the lowest slot
   assign irq_status_sel_out            = sel_q[13:10];
   assign flash_b_ctrl_reg_sel_out      = sel_q[9];
   assign break_addr_high_sel_out       = sel_q[8];
   assign break_addr_low_sel_out        = sel_q[7];
   assign break_ctrl_state_reg_sel_out  = sel_q[6];
   assign low_voltage_state_reg_sel_out = sel_q[5];
   assign flash_b_test_reg_sel_out      = sel_q[4];
   assign flash_a_test_reg_sel_out      = sel_q[3];
   assign flash_a_protect_reg_sel_out   = sel_q[2];
   assign flash_b_protect_reg_sel_out   = sel_q[1];
   assign reserved_hit_out              = sel_q[0];
   assign illegal_addr_rst_out = illegal_q;
   assign region_out = region_q;
endmodule

// *** test/addr_decoder_chk.sv ***
// port-level checks on the address decoder
`timescale 1ns/1ps
module addr_decoder_chk (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [15:0] addr_in,
   input wire logic        rd_in,
   input wire logic        wr_in,
   input wire logic        can_sel_out,
   input wire logic        illegal_addr_rst_out,
   input wire logic [3:0]  irq_status_sel_out,
   input wire logic        break_state_reg_sel_out,
   input wire logic        reset_cause_reg_sel_out,
   input wire logic        reserved_hit_out,
   input wire logic        flash_a_protect_reg_sel_out,
   input wire logic        flash_b_protect_reg_sel_out,
   input wire addr_decoder_pkg::region_e region_out
);
   wire logic acc = rd_in | wr_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   a_can_window: assert property (
      acc && addr_in[15:7] == 9'h00a |=> can_sel_out) else $error("can miss");
   a_illegal_hit: assert property (
      acc && addr_in == 16'hfe0f |=> illegal_addr_rst_out
      && region_out == addr_decoder_pkg::REG_UNIMPL) else $error("no illegal");
   a_illegal_cause: assert property (
      illegal_addr_rst_out |-> $past(addr_in) == 16'hfe0f && $past(acc))
      else $error("stray illegal");
   a_no_strobe_quiet: assert property (
      !acc |=> !illegal_addr_rst_out && !can_sel_out
      && irq_status_sel_out == 4'h0) else $error("select without strobe");
   a_irq_order: assert property (
      acc && addr_in[15:2] == 14'h3f81 |=> irq_status_sel_out
      == 4'h1 << $past(addr_in[1:0])) else $error("irq status order");
   a_break_pair: assert property (
      acc && addr_in[15:1] == 15'h7f00 |=> {break_state_reg_sel_out,
      reset_cause_reg_sel_out} == ($past(addr_in[0]) ? 2'b01 : 2'b10))
      else $error("break pair");
   a_mon_compat: assert property (
      acc && addr_in[15:4] == 12'hfe1 |=> reserved_hit_out
      && !illegal_addr_rst_out) else $error("compat area");
   a_protect_pair: assert property (
      acc && addr_in[15:1] == 15'h7fc0 |=> {flash_a_protect_reg_sel_out,
      flash_b_protect_reg_sel_out} == ($past(addr_in[0]) ? 2'b01 : 2'b10))
      else $error("protect pair");
endmodule
bind system_address_decoder addr_decoder_chk chk (.*);

// *** test/cpu_bus_model.sv ***
// cpu bus master model: idle, full address sweep or random traffic
`timescale 1ns/1ps
module cpu_bus_model (
   input  wire logic        clk_in,
   input  wire logic [1:0]  mode_in,
   output logic      [15:0] addr_out,
   output logic             rd_out,
   output logic             wr_out
);
   integer      seed = 1136;
   logic [31:0] r;
   logic [15:0] na;
   logic [15:0] cnt_q = 16'h0;
   logic        rsv;
   logic        sw;
   initial
   begin
      addr_out = 16'h0;
      rd_out = 1'b0;
      wr_out = 1'b0;
   end
   always @(negedge clk_in)
   begin
      r = $random(seed);
      sw = mode_in == 2'h1;
      // bias half the draws onto the register pages
      na = r[16] ? {7'h7f, r[17], r[17], 3'h0, r[3:0]} : r[15:0];
      rsv = na inside {16'hfe02, [16'h1b80:16'h1dff], [16'h1e10:16'h1e1f],
         [16'hfe10:16'hfe1f], [16'hff82:16'hff87], [16'hff89:16'hffcb]};
      cnt_q <= sw ? cnt_q + 16'h1 : 16'h0;
      addr_out <= sw ? cnt_q : na;
      // only the sweep enters reserved holes, to see them decoded
      rd_out <= sw ? cnt_q[0] : mode_in[1] & r[20] & !rsv;
      wr_out <= sw ? !cnt_q[0] : mode_in[1] & !r[20] & r[21] & !rsv;
   end
endmodule

// *** test/tb.sv ***
// self-checking bench for the system address decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic [15:0] addr_in, a_s;
   logic        rd_in, wr_in, s_s, r_s, m_s;
   logic io_lo_sel_out, ram_a_sel_out, io_hi_sel_out, flash_b_sel_out;
   logic can_sel_out, ram_b_sel_out, mon_rom_sel_out, flash_a_sel_out;
   logic vector_sel_out, break_state_reg_sel_out, reset_cause_reg_sel_out;
   logic break_flag_ctrl_reg_sel_out, flash_b_ctrl_reg_sel_out;
   logic break_addr_high_sel_out, break_addr_low_sel_out;
   logic break_ctrl_state_reg_sel_out, low_voltage_state_reg_sel_out;
   logic flash_b_test_reg_sel_out, flash_a_test_reg_sel_out;
   logic flash_a_protect_reg_sel_out, flash_b_protect_reg_sel_out;
   logic reserved_hit_out, illegal_addr_rst_out;
   logic [3:0]  irq_status_sel_out, ei;
   logic [22:0] got, ex;
   addr_decoder_pkg::region_e region_out, er;
   int fails = 0, checked = 0, cyc = 0, k;
   int fl_n = 0, ram_n = 0, vec_n = 0, can_n = 0;
   // upper bound of each range in order, then its region ordinal
   logic [15:0] top [21] = '{16'h3f, 16'h43f, 16'h461, 16'h4ff, 16'h57f,
      16'h97f, 16'h1b7f, 16'h1dff, 16'h1e0f, 16'h1e1f, 16'h7fff, 16'hfdff,
      16'hfe0f, 16'hfe1f, 16'hff7f, 16'hff80, 16'hff81, 16'hff87, 16'hff88,
      16'hffcb, 16'hffff};
   int rv [21] = '{0, 1, 2, 3, 4, 5, 3, 22, 6, 22, 3, 7, 0, 22, 6, 19, 20, 22,
      24, 22, 21};
   int fe_tab [16] = '{8, 9, 22, 10, 11, 11, 11, 11, 12, 13, 14, 15, 16, 17,
      18, 23};
   assign got = {reserved_hit_out, vector_sel_out,
      flash_b_protect_reg_sel_out, flash_a_protect_reg_sel_out,
      flash_a_test_reg_sel_out, flash_b_test_reg_sel_out,
      low_voltage_state_reg_sel_out, break_ctrl_state_reg_sel_out,
      break_addr_low_sel_out, break_addr_high_sel_out,
      flash_b_ctrl_reg_sel_out, |irq_status_sel_out,
      break_flag_ctrl_reg_sel_out, reset_cause_reg_sel_out,
      break_state_reg_sel_out, flash_a_sel_out, mon_rom_sel_out,
      ram_b_sel_out, can_sel_out, flash_b_sel_out, io_hi_sel_out,
      ram_a_sel_out, io_lo_sel_out};
   always #2 clk_in = ~clk_in;
   cpu_bus_model cpu (.clk_in(clk_in), .mode_in(mode), .addr_out(addr_in),
      .rd_out(rd_in), .wr_out(wr_in));
   system_address_decoder DUT (.*);
   // 24 stands for the flash a control slot, which has no port of its own
   function automatic int code(logic [15:0] a);
      if (a[15:4] == 12'hfe0) return fe_tab[a[3:0]];
      for (int i = 0; i < 21; i++) if (a <= top[i]) return rv[i];
      return 21;
   endfunction
   task results;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      a_s <= addr_in;
      s_s <= rd_in | wr_in;
      r_s <= rst_b_in;
      m_s <= mode == 2'h1;
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         results();
      end
   end
   always @(negedge clk_in)
   if (cyc > 1)
   begin
      k = code(a_s);
      ex = (r_s && s_s && k < 23) ? 23'h1 << k : 23'h0;
      ei = (r_s && s_s && k == 11) ? 4'h1 << a_s[1:0] : 4'h0;
      er = r_s ? addr_decoder_pkg::region_e'(k) : addr_decoder_pkg::REG_UNIMPL;
      `CHK(got[21:0], ex[21:0])
      if (s_s) `CHK(got[22], ex[22])
      `CHK(irq_status_sel_out, ei)
      `CHK(illegal_addr_rst_out, r_s && s_s && k == 23)
      `CHK(region_out, er)
      if (m_s)
      begin
         fl_n += got[3] + got[7];
         ram_n += got[1] + got[5];
         vec_n += got[21];
         can_n += got[4];
      end
   end
   initial
   begin
      repeat (10) @(negedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      mode <= 2'h1;
      repeat (65536) @(posedge clk_in);
      mode <= 2'h2;
      repeat (2) @(negedge clk_in);
      `CHK(fl_n, 62078)
      `CHK(ram_n, 2048)
      `CHK(vec_n, 52)
      `CHK(can_n, 128)
      repeat (2000) @(negedge clk_in);
      rst_b_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      rst_b_in <= 1'b1;
      repeat (1000) @(negedge clk_in);
      mode <= 2'h0;
      repeat (200) @(negedge clk_in);
      results();
   end
endmodule
